// *** verilog/pmic_serial_ctrl.sv ***
// Serial control logic: shift register, control registers, diagnostic decoder
// and non-volatile memory latch and programming control.
// Assumes the host stops the serial clock before pulsing either load strobe and
// that the serial clock period is at least eight system clock periods.
//
// Operation
// - Mode select low gives normal access to the control registers.
// - Frames are 48 bits; bit 47 is the last bit shifted in.
// - After 48 bits the parity result shows on serial output; load strobe commits.
// - In normal mode the serial output carries the parity check result.
// - In normal mode setup and trim values come from stored memory contents.
// - Mode select high enters diagnostic mode with access to both memories.
// - In diagnostic mode the load strobe writes registers unchecked; output shows shift register.
// - Unchecked write needs no decoder operation, only the output differs.
// - Operations 0 to 7 are chosen by the top three shift register bits.
// - Operation 0 copies control registers into the shift register for readout.
// - Operations 2 and 5 copy user and trim memory into the shift register.
// - Operation 3 copies captured protection states into the shift register.
// - Captured protection states clear when power-on request goes high.
// - Operation 1 latches shifted data as pending user setup contents.
// - Latched data replaces stored contents until mode select returns low.
// - Operation 4 latches trim data; operation 7 programs it.
// - Operation 6 after operation 1 programs latched data into user memory.
// - User programming lasts as long as the strobe with voltage applied.
// - Trim programming timing is gated by write protection.
// - Channels switched off stay off until enabled; switching off is immediate.
`timescale 1ns/10ps
`default_nettype none

module pmic_serial_ctrl #(
    parameter int SR_W   = pmic_serial_pkg::SR_W,
    parameter int PROT_W = pmic_serial_pkg::PROT_W,
    parameter int CH_W   = pmic_serial_pkg::CH_W
) (
    // System clock and reset.
    input  wire logic              clk_i,
    input  wire logic              rst_b_i,
    // Serial link from the host.
    input  wire logic              link_clk_i,
    input  wire logic              din_i,
    input  wire logic              load_strobe_i,
    input  wire logic              diag_load_strobe_i,
    input  wire logic              mode_sel_i,
    output logic                   dout_o,
    // Power and protection pins.
    input  wire logic              power_on_request_i,
    input  wire logic [PROT_W-1:0] prot_event_i,
    // Memory programming pins.
    input  wire logic              nvm_program_voltage_i,
    input  wire logic              nvm_program_switch_i,
    input  wire logic              trim_protect_i,
    // Memory macro interface.
    input  wire logic [SR_W-1:0]   user_nvm_i,
    input  wire logic [SR_W-1:0]   trim_nvm_i,
    output logic [SR_W-1:0]        user_wdata_o,
    output logic [SR_W-1:0]        trim_wdata_o,
    output logic                   user_prog_o,
    output logic                   trim_prog_o,
    // Values seen by the regulator blocks.
    output logic [SR_W-1:0]        setup_o,
    output logic [SR_W-1:0]        trim_o,
    output logic [CH_W-1:0]        chan_en_o
);

    localparam int LVL_N = pmic_serial_pkg::LVL_N;

    // Parity of a whole frame against the expected value.
    function automatic logic parity_pass(input logic [SR_W-1:0] w);
        return (^w) == pmic_serial_pkg::PARITY_GOOD;
    endfunction

    // Link domain: capture the data bit and announce each edge by a toggle.
    logic din_cap_r;
    logic din_cap_nxt;
    logic ev_tgl_r;
    logic ev_tgl_nxt;

    // Sampled on the link clock itself, so din needs no further synchroniser.
    always_comb begin
        din_cap_nxt = din_i;
        ev_tgl_nxt  = ~ev_tgl_r;
    end

    always_ff @(posedge link_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            din_cap_r <= 1'b0;
            ev_tgl_r  <= 1'b0;
        end else begin
            din_cap_r <= din_cap_nxt;
            ev_tgl_r  <= ev_tgl_nxt;
        end
    end

    // System domain synchronisers for the toggle, strobes and levels.
    logic [LVL_N-1:0]  lvl_in;
    logic [LVL_N-1:0]  lvl_s1_r;
    logic [LVL_N-1:0]  lvl_s2_r;
    logic [LVL_N-1:0]  lvl_s3_r;
    logic [PROT_W-1:0] prot_s1_r;
    logic [PROT_W-1:0] prot_s2_r;
    logic              ev_s1_r;
    logic              ev_s2_r;
    logic              ev_s3_r;

    assign lvl_in = {trim_protect_i, nvm_program_switch_i, nvm_program_voltage_i,
                     power_on_request_i, diag_load_strobe_i, load_strobe_i, mode_sel_i};

    // The third stage only feeds edge detection; the first stage feeds nothing else.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lvl_s1_r  <= '0;
            lvl_s2_r  <= '0;
            lvl_s3_r  <= '0;
            prot_s1_r <= '0;
            prot_s2_r <= '0;
            ev_s1_r   <= 1'b0;
            ev_s2_r   <= 1'b0;
            ev_s3_r   <= 1'b0;
        end else begin
            lvl_s1_r  <= lvl_in;
            lvl_s2_r  <= lvl_s1_r;
            lvl_s3_r  <= lvl_s2_r;
            prot_s1_r <= prot_event_i;
            prot_s2_r <= prot_s1_r;
            ev_s1_r   <= ev_tgl_r;
            ev_s2_r   <= ev_s1_r;
            ev_s3_r   <= ev_s2_r;
        end
    end

    // Decoded events and levels in the system domain.
    logic                      bit_ev;
    logic                      test_q;
    logic                      ld_rise;
    logic                      tld_q;
    logic                      tld_rise;
    logic                      pwr_rise;
    logic                      parity_ok;
    pmic_serial_pkg::diag_op_t op;

    assign bit_ev    = ev_s2_r ^ ev_s3_r;
    assign test_q    = lvl_s2_r[pmic_serial_pkg::LVL_MODE];
    assign ld_rise   = lvl_s2_r[pmic_serial_pkg::LVL_LD] & ~lvl_s3_r[pmic_serial_pkg::LVL_LD];
    assign tld_q     = lvl_s2_r[pmic_serial_pkg::LVL_TLD];
    assign tld_rise  = tld_q & ~lvl_s3_r[pmic_serial_pkg::LVL_TLD];
    assign pwr_rise  = lvl_s2_r[pmic_serial_pkg::LVL_PWR] & ~lvl_s3_r[pmic_serial_pkg::LVL_PWR];

    // Main state: shift register, registers, latches and registered outputs.
    logic [SR_W-1:0]   sr_r,        sr_nxt;
    logic [SR_W-1:0]   ctrl_r,      ctrl_nxt;
    logic [PROT_W-1:0] prot_r,      prot_nxt;
    logic [SR_W-1:0]   user_lat_r,  user_lat_nxt;
    logic [SR_W-1:0]   trim_lat_r,  trim_lat_nxt;
    logic              user_flag_r, user_flag_nxt;
    logic              trim_flag_r, trim_flag_nxt;
    logic              dout_nxt;
    logic [SR_W-1:0]   setup_nxt;
    logic [SR_W-1:0]   trim_out_nxt;
    logic [CH_W-1:0]   chan_en_nxt;
    logic              user_prog_nxt;
    logic              trim_prog_nxt;

    // Parity and select code are both taken from the registered shift register.
    assign parity_ok = parity_pass(sr_r);
    assign op        = pmic_serial_pkg::diag_op_t'(
                           sr_r[pmic_serial_pkg::SEL_MSB:pmic_serial_pkg::SEL_LSB]);

    // A copy on the diagnostic strobe overrides a shift in the same cycle; the
    // host keeps the link clock still around strobes, so the two never meet.
    always_comb begin
        sr_nxt        = sr_r;
        ctrl_nxt      = ctrl_r;
        user_lat_nxt  = user_lat_r;
        trim_lat_nxt  = trim_lat_r;
        user_flag_nxt = user_flag_r;
        trim_flag_nxt = trim_flag_r;
        if (bit_ev) begin
            sr_nxt = {din_cap_r, sr_r[SR_W-1:1]};
        end
        if (ld_rise && (test_q || parity_ok)) begin
            ctrl_nxt = sr_r;
        end
        if (test_q && tld_rise) begin
            unique case (op)
                pmic_serial_pkg::OP_READ_REGS: begin
                    sr_nxt = ctrl_r;
                end
                pmic_serial_pkg::OP_LATCH_USER: begin
                    user_lat_nxt  = sr_r;
                    user_flag_nxt = 1'b1;
                end
                pmic_serial_pkg::OP_READ_USER: begin
                    sr_nxt = user_nvm_i;
                end
                pmic_serial_pkg::OP_READ_PROT: begin
                    sr_nxt = {{(SR_W-PROT_W){1'b0}}, prot_r};
                end
                pmic_serial_pkg::OP_LATCH_TRIM: begin
                    trim_lat_nxt  = sr_r;
                    trim_flag_nxt = 1'b1;
                end
                pmic_serial_pkg::OP_READ_TRIM: begin
                    sr_nxt = trim_nvm_i;
                end
                pmic_serial_pkg::OP_PROG_USER, pmic_serial_pkg::OP_PROG_TRIM: begin
                    sr_nxt = sr_r;
                end
            endcase
        end
        if (!test_q) begin
            user_flag_nxt = 1'b0;
            trim_flag_nxt = 1'b0;
        end
        // A new event in the clearing cycle is kept, so set wins over clear.
        if (pwr_rise) begin
            prot_nxt = prot_s2_r;
        end else begin
            prot_nxt = prot_r | prot_s2_r;
        end
        // Registered rather than raw, so the output cannot glitch.
        dout_nxt      = test_q ? sr_r[0] : parity_ok;
        setup_nxt     = (test_q && user_flag_r) ? user_lat_r : user_nvm_i;
        trim_out_nxt  = (test_q && trim_flag_r) ? trim_lat_r : trim_nvm_i;
        chan_en_nxt   = ctrl_r[CH_W-1:0];
        user_prog_nxt = test_q && tld_q && (op == pmic_serial_pkg::OP_PROG_USER)
                        && user_flag_r && lvl_s2_r[pmic_serial_pkg::LVL_VOLT]
                        && lvl_s2_r[pmic_serial_pkg::LVL_SW];
        trim_prog_nxt = test_q && tld_q && (op == pmic_serial_pkg::OP_PROG_TRIM)
                        && trim_flag_r && lvl_s2_r[pmic_serial_pkg::LVL_VOLT]
                        && lvl_s2_r[pmic_serial_pkg::LVL_SW]
                        && !lvl_s2_r[pmic_serial_pkg::LVL_WP];
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sr_r         <= '0;
            ctrl_r       <= pmic_serial_pkg::CTRL_RESET;
            prot_r       <= '0;
            user_lat_r   <= '0;
            trim_lat_r   <= '0;
            user_flag_r  <= 1'b0;
            trim_flag_r  <= 1'b0;
            dout_o       <= 1'b0;
            setup_o      <= '0;
            trim_o       <= '0;
            chan_en_o    <= '0;
            user_prog_o  <= 1'b0;
            trim_prog_o  <= 1'b0;
        end else begin
            sr_r         <= sr_nxt;
            ctrl_r       <= ctrl_nxt;
            prot_r       <= prot_nxt;
            user_lat_r   <= user_lat_nxt;
            trim_lat_r   <= trim_lat_nxt;
            user_flag_r  <= user_flag_nxt;
            trim_flag_r  <= trim_flag_nxt;
            dout_o       <= dout_nxt;
            setup_o      <= setup_nxt;
            trim_o       <= trim_out_nxt;
            chan_en_o    <= chan_en_nxt;
            user_prog_o  <= user_prog_nxt;
            trim_prog_o  <= trim_prog_nxt;
        end
    end

    // Write data for the memory macro comes straight from the latches.
    assign user_wdata_o = user_lat_r;
    assign trim_wdata_o = trim_lat_r;

    // Checks on the system domain.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence diag_ld_s;
        test_q && tld_rise;
    endsequence

    sequence norm_ld_s;
        !test_q && ld_rise;
    endsequence

    shift_in_a: assert property (bit_ev && !(test_q && tld_rise) |=>
        sr_r[SR_W-1] == $past(din_cap_r) && sr_r[SR_W-2:0] == $past(sr_r[SR_W-1:1]))
        else $error("Shift register did not take the captured bit at its top.");

    good_write_a: assert property (norm_ld_s ##0 parity_ok |=>
        ctrl_r == $past(sr_r) ##1 chan_en_o == $past(sr_r[CH_W-1:0], 2))
        else $error("Frame with good parity was not committed to the channels.");

    bad_parity_a: assert property (norm_ld_s ##0 !parity_ok |=> ctrl_r == $past(ctrl_r))
        else $error("Frame with bad parity changed the control registers.");

    norm_dout_a: assert property (!test_q ##1 !test_q |-> dout_o == $past(parity_pass(sr_r)))
        else $error("Serial output does not carry the parity result.");

    test_write_a: assert property (test_q && ld_rise |=> ctrl_r == $past(sr_r))
        else $error("Unchecked write did not reach the control registers.");

    read_regs_a: assert property (diag_ld_s ##0 op == pmic_serial_pkg::OP_READ_REGS |=>
        sr_r == $past(ctrl_r) ##1 (!test_q || dout_o == $past(ctrl_r[0], 2)))
        else $error("Register readout did not load the shift register.");

    prot_clear_a: assert property (pwr_rise |=> prot_r == $past(prot_s2_r))
        else $error("Protection states were not cleared on power-on request.");

    latch_use_a: assert property (diag_ld_s ##0 op == pmic_serial_pkg::OP_LATCH_USER
        ##1 test_q [*2] |-> setup_o == $past(sr_r, 2))
        else $error("Latched user data is not seen by the regulator blocks.");

    latch_drop_a: assert property ($fell(test_q) |=> !user_flag_r && !trim_flag_r)
        else $error("Latched data still used after leaving diagnostic mode.");

    user_prog_a: assert property (user_prog_o |-> $past(user_flag_r && tld_q))
        else $error("User memory programmed without latched data or strobe.");

    trim_guard_a: assert property (trim_prog_o |->
        !$past(lvl_s2_r[pmic_serial_pkg::LVL_WP]) && $past(trim_flag_r))
        else $error("Trim memory programmed while write protected.");

    trim_use_a: assert property (diag_ld_s ##0 op == pmic_serial_pkg::OP_LATCH_TRIM
        ##1 test_q [*2] |-> trim_o == $past(sr_r, 2))
        else $error("Latched trim data is not seen by the regulator blocks.");

    diag_dout_a: assert property (test_q ##1 test_q |-> dout_o == $past(sr_r[0]))
        else $error("Serial output does not carry the shift register in diagnostic mode.");

    read_user_a: assert property (diag_ld_s ##0 op == pmic_serial_pkg::OP_READ_USER |=>
        sr_r == $past(user_nvm_i))
        else $error("User memory readout did not load the shift register.");

    read_trim_a: assert property (diag_ld_s ##0 op == pmic_serial_pkg::OP_READ_TRIM |=>
        sr_r == $past(trim_nvm_i))
        else $error("Trim memory readout did not load the shift register.");

    read_prot_a: assert property (diag_ld_s ##0 op == pmic_serial_pkg::OP_READ_PROT |=>
        sr_r == {{(SR_W-PROT_W){1'b0}}, $past(prot_r)})
        else $error("Protection readout did not load the shift register.");

    prot_keep_a: assert property (!pwr_rise |=>
        (prot_r & $past(prot_r)) == $past(prot_r))
        else $error("A captured protection state was lost without power-on request.");

    chan_map_a: assert property (1'b1 |=> chan_en_o == $past(ctrl_r[CH_W-1:0]))
        else $error("Channel enables do not follow the control register.");

    user_volt_a: assert property (user_prog_o |->
        $past(lvl_s2_r[pmic_serial_pkg::LVL_VOLT] && lvl_s2_r[pmic_serial_pkg::LVL_SW]))
        else $error("User memory programmed without programming voltage.");

endmodule

`default_nettype wire

// *** pkg/pmic_serial_pkg.sv ***
// Constants and types shared by the serial control block of the power device.
// Assumes a 48-bit frame with the diagnostic select code in its top three bits.
package pmic_serial_pkg;

    // Frame geometry.
    localparam int SR_W    = 48;
    localparam int SEL_MSB = 47;
    localparam int SEL_LSB = 45;

    // Width of the protection state field and of the channel enable field.
    localparam int PROT_W  = 8;
    localparam int CH_W    = 8;

    // Control register value after reset: every channel enabled.
    localparam logic [SR_W-1:0] CTRL_RESET = 48'h0000_0000_00ff;

    // Expected value of the XOR over a whole frame for the parity check to pass.
    localparam logic PARITY_GOOD = 1'b0;

    // Number of asynchronous level inputs that pass a synchroniser.
    localparam int LVL_N = 7;

    // Positions of the level inputs inside the synchroniser vector.
    localparam int LVL_MODE = 0;
    localparam int LVL_LD   = 1;
    localparam int LVL_TLD  = 2;
    localparam int LVL_PWR  = 3;
    localparam int LVL_VOLT = 4;
    localparam int LVL_SW   = 5;
    localparam int LVL_WP   = 6;

    // Diagnostic operations, each select code equal to its operation number.
    typedef enum logic [2:0] {
        OP_READ_REGS  = 3'h0,
        OP_LATCH_USER = 3'h1,
        OP_READ_USER  = 3'h2,
        OP_READ_PROT  = 3'h3,
        OP_LATCH_TRIM = 3'h4,
        OP_READ_TRIM  = 3'h5,
        OP_PROG_USER  = 3'h6,
        OP_PROG_TRIM  = 3'h7
    } diag_op_t;

endpackage

// *** sim/host_model.sv ***
// Host model: drives the serial clock, serial data and both load strobes.
// Assumes the bench calls its tasks from one process and supplies the system clock.
`timescale 1ns/10ps
`default_nettype none

module host_model (
    // System clock, used to pace the strobes and the wait after each frame.
    input  wire logic clk_i,
    // Serial link and strobes toward the device.
    output logic      link_clk_o,
    output logic      din_o,
    output logic      load_strobe_o,
    output logic      diag_load_strobe_o
);
    // Idle: the link clock stands still low and both strobes are low.
    initial begin
        link_clk_o         = 1'b0;
        din_o              = 1'b0;
        load_strobe_o      = 1'b0;
        diag_load_strobe_o = 1'b0;
    end

    // One 32 ns link cycle; data settles half a period before the rising edge.
    task automatic tick(input logic b);
        din_o = b;
        #16 link_clk_o = 1'b1;
        #8 din_o = ~b; // Released data never repeats the old bit.
        #8 link_clk_o = 1'b0;
    endtask

    // Whole frame, bit 0 first and bit 47 last, then the clock is stopped.
    task automatic send(input logic [47:0] f);
        #7; // Keeps the link phase apart from the system clock.
        for (int i = 0; i < 48; i++) begin
            tick(f[i]);
        end
        repeat (8) @(negedge clk_i);
    endtask

    // Strobe held for n system cycles, then low long enough to be seen as separate.
    task automatic pulse(input bit diag, input int n);
        @(negedge clk_i);
        {diag_load_strobe_o, load_strobe_o} = diag ? 2'b10 : 2'b01;
        repeat (n) @(negedge clk_i);
        {diag_load_strobe_o, load_strobe_o} = 2'b00;
        repeat (8) @(negedge clk_i);
    endtask
endmodule

`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for the serial control block with a host model on the link.
// Assumes the design package is compiled first; memory contents are fixed patterns.
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    logic        clk_i, rst_b_i, link_clk, din, ld, diag_load_strobe, mode, pwr, volt, sw, wp;
    logic        dout, uprog, tprog;
    logic [7:0]  prot, chan;
    logic [47:0] unvm, tnvm, uwd, twd, setup, trim;
    int          error_cnt, checked, cyc;

    host_model host (.clk_i(clk_i), .link_clk_o(link_clk), .din_o(din),
                     .load_strobe_o(ld), .diag_load_strobe_o(diag_load_strobe));

    pmic_serial_ctrl DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .link_clk_i(link_clk),
        .din_i(din), .load_strobe_i(ld), .diag_load_strobe_i(diag_load_strobe), .mode_sel_i(mode),
        .dout_o(dout), .power_on_request_i(pwr), .prot_event_i(prot),
        .nvm_program_voltage_i(volt), .nvm_program_switch_i(sw), .trim_protect_i(wp),
        .user_nvm_i(unvm), .trim_nvm_i(tnvm), .user_wdata_o(uwd), .trim_wdata_o(twd),
        .user_prog_o(uprog), .trim_prog_o(tprog), .setup_o(setup), .trim_o(trim),
        .chan_en_o(chan));

    // System clock, 4 ns period.
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // A hang is cut short well above the expected run of about 8800 cycles.
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt++;
            conclude();
        end
    end

    task automatic conclude();
        if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // Makes the XOR over the frame zero by adjusting bit 44.
    function automatic logic [47:0] even(input logic [47:0] f);
        f[44] = f[44] ^ (^f);
        return f;
    endfunction

    // Selects an operation, strobes it, then reads 48 bits back LSB first.
    task automatic rd(input logic [2:0] op, input logic [47:0] exp);
        host.send({op, 45'h0000_0000_0000});
        host.pulse(1'b1, 4);
        for (int i = 0; i < 48; i++) begin
            chk(48'(dout), 48'(exp[i]));
            host.tick(1'b0);
            idle(8);
        end
    endtask

    // Programming strobe of eight cycles; the output is looked at in mid-pulse.
    task automatic prog(input bit tsel, input logic e);
        fork
            host.pulse(1'b1, 8);
            begin
                idle(6);
                chk(48'(tsel ? tprog : uprog), 48'(e));
            end
        join
        chk(48'(tsel ? tprog : uprog), 48'h0000_0000_0000);
    endtask

    // Good frame switches channels off at once; a bad one changes nothing.
    task automatic t_normal();
        logic [47:0] f;
        f = even(48'h0000_0000_000f);
        host.send(f);
        chk(48'(dout), 48'h0000_0000_0001);
        host.pulse(1'b0, 4);
        chk(48'(chan), 48'h0000_0000_000f);
        host.send(f ^ 48'h0000_0000_00f1);
        chk(48'(dout), 48'h0000_0000_0000);
        host.pulse(1'b0, 4);
        chk(48'(chan), 48'h0000_0000_000f);
    endtask

    // Unchecked write in diagnostic mode, then register and memory readback.
    task automatic t_diag();
        mode = 1'b1;
        idle(8);
        host.send(48'h0000_0000_00f1);
        chk(48'(dout), 48'h0000_0000_0001);
        host.pulse(1'b0, 4);
        chk(48'(chan), 48'h0000_0000_00f1);
        rd(3'h0, 48'h0000_0000_00f1);
        rd(3'h2, unvm);
        rd(3'h5, tnvm);
    endtask

    // Captured protection is read before power-on, then cleared by it.
    task automatic t_prot();
        prot = 8'h05;
        idle(4);
        prot = 8'h00;
        rd(3'h3, 48'h0000_0000_0005);
        pwr = 1'b1;
        idle(8);
        rd(3'h3, 48'h0000_0000_0000);
    endtask

    // Latch and program both memories; trim programming honours protection.
    task automatic t_nvm();
        logic [47:0] f;
        f = {3'h1, 45'h0abc_def0_1234};
        host.send(f);
        host.pulse(1'b1, 4);
        chk(uwd, f);
        chk(setup, f);
        host.send({3'h6, 45'h0000_0000_0000});
        volt = 1'b1;
        sw = 1'b1;
        idle(4);
        prog(1'b0, 1'b1);
        f = {3'h4, 45'h1555_5aaa_0f0f};
        host.send(f);
        host.pulse(1'b1, 4);
        chk(twd, f);
        chk(trim, f);
        wp = 1'b1;
        host.send({3'h7, 45'h0000_0000_0000});
        prog(1'b1, 1'b0);
        wp = 1'b0;
        idle(4);
        prog(1'b1, 1'b1);
        volt = 1'b0;
        sw = 1'b0;
        mode = 1'b0;
        idle(8);
        chk(setup, unvm);
        chk(trim, tnvm);
    endtask

    // Main sequence: reset, then every scenario in turn.
    initial begin
        {rst_b_i, mode, pwr, volt, sw, wp} = 6'b00_0000;
        {error_cnt, checked, cyc} = 0;
        prot = 8'h00;
        unvm = 48'h1234_5678_9abc;
        tnvm = 48'h0fed_cba9_8765;
        idle(3);
        rst_b_i = 1'b1;
        idle(4);
        chk(48'(chan), 48'h0000_0000_00ff);
        chk(48'(dout), 48'h0000_0000_0001);
        chk(setup, unvm);
        t_normal();
        t_diag();
        t_prot();
        t_nvm();
        conclude();
    end
endmodule

`default_nettype wire
